// [hdl/ir_pulse_timer_pair.sv]
`timescale 1ns/1ps
`default_nettype none
module ir_pulse_timer_pair #(
   parameter int TICK_DIV = ir_timer_pkg::TICK_DIV_DEFAULT
) (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       inputPinA,
   input  wire logic       inputPinB,
   input  wire logic [7:0] regAddr,
   input  wire logic [7:0] regWrData,
   input  wire logic       regWrEn,
   input  wire logic       regRdEn,
   output logic [7:0]      regRdData,
   output logic            byteTimerOutput,
   output logic            byteTimeoutIrq,
   output logic            byteEdgeIrq,
   output logic            wordCaptureIrq,
   output logic            wordTimeoutIrq
);
   import ir_timer_pkg::*;

   // Control registers
   logic [7:0]  byteCtrl_reg;
   logic [7:0]  sharedCtrl_reg;
   logic [7:0]  wordCtrl_reg;
   logic [2:0]  extraSpare_reg;
   logic [7:0]  highReload_reg;
   logic [7:0]  lowReload_reg;
   logic [15:0] wordReload_reg;
   // Status and captures
   logic        byteTmoSt_reg;
   logic        posSt_reg;
   logic        negSt_reg;
   logic        wordTmoSt_reg;
   logic [7:0]  highCapture_reg;
   logic [7:0]  lowCapture_reg;
   logic [15:0] wordCapture_reg;
   // Timer state
   byteState_t  byteState_reg;
   logic [7:0]  byteCnt_reg;
   logic [15:0] wordCnt_reg;
   logic        wordRun_reg;
   logic        wordArmed_reg;
   logic        wordOnce_reg;
   logic [7:0]  tickCnt_reg;
   logic        tick;
   // Input path
   logic        pinLevel;
   logic        filtLevel;
   logic        prevLevel_reg;
   logic        posEdge;
   logic        negEdge;
   logic        edgeEv;
   // Events
   logic        byteEn;
   logic        demodMode;
   logic        byteActive;
   logic        byteTc;
   logic        byteTmoEv;
   logic        wordEdgeCap;
   logic        wordTmoCap;
   logic        wordTmoEv;
   logic        wrByte;
   logic        wrShared;
   logic        wrWord;

   assign byteEn     = byteCtrl_reg[BC_ENABLE];
   assign demodMode  = byteCtrl_reg[BC_DEMOD];
   assign byteActive = (byteState_reg == BT_FIRST) || (byteState_reg == BT_RUN);
   assign wrByte     = regWrEn && (regAddr == ADDR_BYTE_CTRL);
   assign wrShared   = regWrEn && (regAddr == ADDR_SHARED_CTRL);
   assign wrWord     = regWrEn && (regAddr == ADDR_WORD_CTRL);

   // Timer tick prescaler
   assign tick = (tickCnt_reg == 8'(TICK_DIV - 1));
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tickCnt_reg <= '0;
      end else if (tick) begin
         tickCnt_reg <= '0;
      end else begin
         tickCnt_reg <= tickCnt_reg + 8'h01;
      end
   end

   // Input select and glitch filter
   assign pinLevel = sharedCtrl_reg[SC_PIN_SEL] ? inputPinB : inputPinA;

   glitch_filter filterInst (
      .mclk    (mclk),
      .rstn    (rstn),
      .rawIn   (pinLevel),
      .filtSel (sharedCtrl_reg[SC_FILT_HI:SC_FILT_LO]),
      .filtOut (filtLevel)
   );

   // Edge detector on filtered level
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         prevLevel_reg <= 1'b1; // Matches filter idle level
      end else begin
         prevLevel_reg <= filtLevel;
      end
   end

   assign posEdge = filtLevel && !prevLevel_reg && sharedCtrl_reg[SC_EDGE_LO];
   assign negEdge = !filtLevel && prevLevel_reg && sharedCtrl_reg[SC_EDGE_HI];
   assign edgeEv  = posEdge || negEdge;

   // Byte timer events
   assign byteTc    = byteActive && !demodMode && tick && (byteCnt_reg == BYTE_ONE);
   assign byteTmoEv = demodMode
                      ? (byteActive && !edgeEv && tick && (byteCnt_reg == BYTE_ONE))
                      : (byteTc && (byteCtrl_reg[BC_SINGLE] || byteState_reg == BT_RUN));

   // Byte timer counter and output
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         byteState_reg   <= BT_OFF;
         byteCnt_reg     <= RST_BYTE_REG;
         byteTimerOutput <= 1'b1;
      end else if (!byteEn) begin
         byteState_reg   <= BT_OFF;
         byteTimerOutput <= !sharedCtrl_reg[SC_INIT_VAL];
      end else begin
         case (byteState_reg)
            BT_OFF: begin
               byteTimerOutput <= sharedCtrl_reg[SC_INIT_VAL];
               byteState_reg   <= BT_FIRST;
               if (demodMode) begin
                  byteCnt_reg <= BYTE_RESTART;
               end else if (sharedCtrl_reg[SC_INIT_VAL]) begin
                  byteCnt_reg <= highReload_reg;
               end else begin
                  byteCnt_reg <= lowReload_reg;
               end
            end
            BT_FIRST, BT_RUN: begin
               if (demodMode) begin
                  if (edgeEv) begin
                     byteCnt_reg <= BYTE_RESTART;
                  end else if (tick) begin
                     byteCnt_reg <= byteCnt_reg - BYTE_ONE;
                  end
               end else if (byteTc) begin
                  byteTimerOutput <= !byteTimerOutput;
                  if (byteCtrl_reg[BC_SINGLE]) begin
                     byteCnt_reg   <= '0;
                     byteState_reg <= BT_STOP;
                  end else begin
                     byteState_reg <= BT_RUN;
                     // Output after toggle low selects low reload
                     byteCnt_reg   <= byteTimerOutput ? lowReload_reg : highReload_reg;
                  end
               end else if (tick) begin
                  byteCnt_reg <= byteCnt_reg - BYTE_ONE;
               end
            end
            BT_STOP: begin
               byteCnt_reg <= byteCnt_reg;
            end
            default: begin
               byteState_reg <= BT_OFF;
            end
         endcase
      end
   end

   // Demodulation captures
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         highCapture_reg <= RST_BYTE_REG;
         lowCapture_reg  <= RST_BYTE_REG;
      end else if (demodMode && byteActive) begin
         if (negEdge) begin
            highCapture_reg <= byteCnt_reg;
         end
         if (posEdge) begin
            lowCapture_reg <= byteCnt_reg;
         end
      end
   end

   // Word timer events
   assign wordEdgeCap = wordRun_reg && edgeEv && (!wordOnce_reg || wordArmed_reg);
   assign wordTmoCap  = wordRun_reg && wordOnce_reg && byteTmoEv && !wordEdgeCap;
   assign wordTmoEv   = wordRun_reg && tick && !wordEdgeCap && (wordCnt_reg == WORD_ONE);

   // Word timer counter
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wordCnt_reg <= RST_WORD_REG;
         wordRun_reg <= 1'b0;
      end else if (!wordCtrl_reg[WC_ENABLE]) begin
         wordRun_reg <= 1'b0;
      end else if (!wordRun_reg) begin
         wordCnt_reg <= wordReload_reg;
         wordRun_reg <= 1'b1;
      end else if (wordEdgeCap) begin
         wordCnt_reg <= wordReload_reg;
      end else if (tick) begin
         wordCnt_reg <= wordCnt_reg - WORD_ONE;
      end
   end

   // Word capture register
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wordCapture_reg <= RST_WORD_REG;
      end else if (wordEdgeCap || wordTmoCap) begin
         wordCapture_reg <= wordCnt_reg;
      end
   end

   // Once-mode arming, re-armed by mode bit rising
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wordOnce_reg  <= 1'b0;
         wordArmed_reg <= 1'b1;
      end else begin
         wordOnce_reg <= wordCtrl_reg[WC_ONCE];
         if (wordCtrl_reg[WC_ONCE] && !wordOnce_reg) begin
            wordArmed_reg <= 1'b1;
         end else if (!wordRun_reg) begin
            wordArmed_reg <= 1'b1;
         end else if (wordEdgeCap) begin
            wordArmed_reg <= 1'b0;
         end
      end
   end

   // Control register writes
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         byteCtrl_reg   <= RST_BYTE_REG;
         sharedCtrl_reg <= RST_BYTE_REG;
         wordCtrl_reg   <= RST_BYTE_REG;
         extraSpare_reg <= '0;
         highReload_reg <= RST_BYTE_REG;
         lowReload_reg  <= RST_BYTE_REG;
         wordReload_reg <= RST_WORD_REG;
      end else if (regWrEn) begin
         case (regAddr)
            ADDR_BYTE_CTRL:   byteCtrl_reg <= regWrData;
            ADDR_SHARED_CTRL: begin
               sharedCtrl_reg[7:2] <= regWrData[7:2];
               // In demod mode these bits clear edge status instead
               if (!demodMode) begin
                  sharedCtrl_reg[1:0] <= regWrData[1:0];
               end
            end
            ADDR_WORD_CTRL:   wordCtrl_reg <= regWrData;
            ADDR_EXTRA_CTRL:  extraSpare_reg <= regWrData[7:5];
            ADDR_HIGH_RELOAD: highReload_reg <= regWrData;
            ADDR_LOW_RELOAD:  lowReload_reg <= regWrData;
            ADDR_WORD_RLD_HI: wordReload_reg[15:8] <= regWrData;
            ADDR_WORD_RLD_LO: wordReload_reg[7:0] <= regWrData;
            default: begin
               extraSpare_reg <= extraSpare_reg;
            end
         endcase
      end
   end

   // Sticky status, set wins over write-one clear
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         byteTmoSt_reg <= 1'b0;
         posSt_reg     <= 1'b0;
         negSt_reg     <= 1'b0;
         wordTmoSt_reg <= 1'b0;
      end else begin
         if (byteTmoEv) begin
            byteTmoSt_reg <= 1'b1;
         end else if (wrByte && regWrData[BC_TMO_ST]) begin
            byteTmoSt_reg <= 1'b0;
         end
         if (demodMode && byteActive && posEdge) begin
            posSt_reg <= 1'b1;
         end else if (wrShared && demodMode && regWrData[SC_POS_ST]) begin
            posSt_reg <= 1'b0;
         end
         if (demodMode && byteActive && negEdge) begin
            negSt_reg <= 1'b1;
         end else if (wrShared && demodMode && regWrData[SC_NEG_ST]) begin
            negSt_reg <= 1'b0;
         end
         if (wordTmoEv) begin
            wordTmoSt_reg <= 1'b1;
         end else if (wrWord && regWrData[WC_TMO_ST]) begin
            wordTmoSt_reg <= 1'b0;
         end
      end
   end

   // Interrupt request pulses
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         byteTimeoutIrq <= 1'b0;
         byteEdgeIrq    <= 1'b0;
         wordCaptureIrq <= 1'b0;
         wordTimeoutIrq <= 1'b0;
      end else begin
         byteTimeoutIrq <= byteTmoEv && byteCtrl_reg[BC_TMO_IE];
         byteEdgeIrq    <= demodMode && byteActive && edgeEv && byteCtrl_reg[BC_EDGE_IE];
         wordCaptureIrq <= (wordEdgeCap || wordTmoCap) && wordCtrl_reg[WC_CAP_IE];
         wordTimeoutIrq <= wordTmoEv && wordCtrl_reg[WC_TMO_IE];
      end
   end

   // Registered read port
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         regRdData <= RD_UNMAPPED;
      end else if (regRdEn) begin
         case (regAddr)
            ADDR_BYTE_CTRL: regRdData <= {byteCtrl_reg[7:6], byteTmoSt_reg, byteCtrl_reg[4:0]};
            ADDR_SHARED_CTRL: begin
               regRdData <= demodMode ? {sharedCtrl_reg[7:2], posSt_reg, negSt_reg}
                                      : sharedCtrl_reg;
            end
            ADDR_WORD_CTRL:    regRdData <= {wordCtrl_reg[7:6], wordTmoSt_reg, wordCtrl_reg[4:0]};
            ADDR_EXTRA_CTRL:   regRdData <= {extraSpare_reg, EXTRA_RSVD_VAL};
            ADDR_HIGH_RELOAD:  regRdData <= highReload_reg;
            ADDR_LOW_RELOAD:   regRdData <= lowReload_reg;
            ADDR_HIGH_CAPTURE: regRdData <= highCapture_reg;
            ADDR_LOW_CAPTURE:  regRdData <= lowCapture_reg;
            ADDR_WORD_RLD_HI:  regRdData <= wordReload_reg[15:8];
            ADDR_WORD_RLD_LO:  regRdData <= wordReload_reg[7:0];
            ADDR_WORD_CAP_HI:  regRdData <= wordCapture_reg[15:8];
            ADDR_WORD_CAP_LO:  regRdData <= wordCapture_reg[7:0];
            default:           regRdData <= RD_UNMAPPED;
         endcase
      end
   end

endmodule : ir_pulse_timer_pair
`default_nettype wire

// [shared/ir_timer_pkg.sv]
package ir_timer_pkg;

   // Register indices on the 8-bit register port
   localparam logic [7:0] ADDR_BYTE_CTRL    = 8'h00;
   localparam logic [7:0] ADDR_SHARED_CTRL  = 8'h01;
   localparam logic [7:0] ADDR_WORD_CTRL    = 8'h02;
   localparam logic [7:0] ADDR_EXTRA_CTRL   = 8'h03;
   localparam logic [7:0] ADDR_HIGH_RELOAD  = 8'h04;
   localparam logic [7:0] ADDR_LOW_RELOAD   = 8'h05;
   localparam logic [7:0] ADDR_HIGH_CAPTURE = 8'h06;
   localparam logic [7:0] ADDR_LOW_CAPTURE  = 8'h07;
   localparam logic [7:0] ADDR_WORD_RLD_HI  = 8'h08;
   localparam logic [7:0] ADDR_WORD_RLD_LO  = 8'h09;
   localparam logic [7:0] ADDR_WORD_CAP_HI  = 8'h0a;
   localparam logic [7:0] ADDR_WORD_CAP_LO  = 8'h0b;

   // byte_timer_control fields
   localparam int BC_ENABLE   = 7;
   localparam int BC_SINGLE   = 6;
   localparam int BC_TMO_ST   = 5;
   localparam int BC_DEMOD    = 4;
   localparam int BC_EDGE_IE  = 2;
   localparam int BC_TMO_IE   = 1;

   // shared_timer_control fields
   localparam int SC_PIN_SEL  = 7;
   localparam int SC_EDGE_HI  = 5;
   localparam int SC_EDGE_LO  = 4;
   localparam int SC_FILT_HI  = 3;
   localparam int SC_FILT_LO  = 2;
   localparam int SC_INIT_VAL = 1;
   localparam int SC_POS_ST   = 1;
   localparam int SC_NEG_ST   = 0;

   // word_timer_control fields
   localparam int WC_ENABLE   = 7;
   localparam int WC_ONCE     = 6;
   localparam int WC_TMO_ST   = 5;
   localparam int WC_CAP_IE   = 2;
   localparam int WC_TMO_IE   = 1;

   // extra_timer_control: low five bits read as ones
   localparam logic [4:0] EXTRA_RSVD_VAL = 5'h1f;

   // Reset values
   localparam logic [7:0]  RST_BYTE_REG  = 8'h00;
   localparam logic [15:0] RST_WORD_REG  = 16'h0000;
   localparam logic [7:0]  RD_UNMAPPED   = 8'h00;

   // Counter constants
   localparam logic [7:0]  BYTE_RESTART  = 8'hff;
   localparam logic [15:0] WORD_ONE      = 16'h0001;
   localparam logic [7:0]  BYTE_ONE      = 8'h01;

   // Glitch filter minimum widths in clock cycles per filter code
   localparam int FILT_WIDTH_W = 4;
   localparam logic [3:0] FILT_MIN_0 = 4'h1;
   localparam logic [3:0] FILT_MIN_1 = 4'h2;
   localparam logic [3:0] FILT_MIN_2 = 4'h4;
   localparam logic [3:0] FILT_MIN_3 = 4'h8;

   // Timer tick prescale, clock cycles per tick
   localparam int TICK_DIV_DEFAULT = 1;

   typedef enum logic [1:0] {BT_OFF, BT_FIRST, BT_RUN, BT_STOP} byteState_t;

endpackage : ir_timer_pkg

// [hdl/glitch_filter.sv]
`timescale 1ns/1ps
`default_nettype none
module glitch_filter (
   input  wire logic       mclk,
   input  wire logic       rstn,
   input  wire logic       rawIn,
   input  wire logic [1:0] filtSel,
   output logic            filtOut
);
   import ir_timer_pkg::*;

   logic [FILT_WIDTH_W-1:0] minWidth;
   logic [FILT_WIDTH_W-1:0] runCnt_reg;
   logic [FILT_WIDTH_W-1:0] runCnt_next;

   // Minimum accepted pulse width per code
   always_comb begin
      case (filtSel)
         2'b00:   minWidth = FILT_MIN_0;
         2'b01:   minWidth = FILT_MIN_1;
         2'b10:   minWidth = FILT_MIN_2;
         default: minWidth = FILT_MIN_3;
      endcase
   end

   assign runCnt_next = runCnt_reg + 1'b1;

   // Level accepted only after it persists minWidth cycles
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         runCnt_reg <= '0;
         filtOut    <= 1'b1; // Pulled-up idle level, no edge after reset
      end else if (rawIn == filtOut) begin
         runCnt_reg <= '0;
      end else if (runCnt_next >= minWidth) begin
         filtOut    <= rawIn;
         runCnt_reg <= '0;
      end else begin
         runCnt_reg <= runCnt_next;
      end
   end

endmodule : glitch_filter
`default_nettype wire

// [dv/ir_timer_checker_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ir_timer_checker
   import ir_timer_pkg::*;
#(
   parameter int TICK_DIV = 1
) (
   input wire logic       mclk,
   input wire logic       rstn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic       regWrEn,
   input wire logic       byteTimerOutput,
   input wire logic       byteTimeoutIrq,
   input wire logic       byteEdgeIrq,
   input wire logic       wordCaptureIrq,
   input wire logic       wordTimeoutIrq
);
   logic [7:0] bCtrl;
   logic [7:0] wCtrl;
   logic       initVal;
   logic [1:0] quiet;

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rstn);

   // Shadow of the written control bits
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bCtrl   <= 8'h00;
         wCtrl   <= 8'h00;
         initVal <= 1'b0;
      end else if (regWrEn) begin
         if (regAddr == ADDR_BYTE_CTRL) begin
            bCtrl <= regWrData;
         end
         if (regAddr == ADDR_WORD_CTRL) begin
            wCtrl <= regWrData;
         end
         if (regAddr == ADDR_SHARED_CTRL && !bCtrl[BC_DEMOD]) begin
            initVal <= regWrData[SC_INIT_VAL];
         end
      end
   end

   // Cycles since a write that can move the idle level
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         quiet <= 2'd0;
      end else if (regWrEn && (regAddr == ADDR_BYTE_CTRL || regAddr == ADDR_SHARED_CTRL)) begin
         quiet <= 2'd0;
      end else if (quiet != 2'd3) begin
         quiet <= quiet + 2'd1;
      end
   end

   chk_idle_level: assert property (
      quiet == 2'd3 && !bCtrl[BC_ENABLE] && !bCtrl[BC_DEMOD] |-> byteTimerOutput == !initVal)
      else $error("idle output is not the inverted initial value");
   chk_enable_load: assert property (
      regWrEn && regAddr == ADDR_BYTE_CTRL && regWrData[BC_ENABLE] && !regWrData[BC_DEMOD]
      && !bCtrl[BC_ENABLE] |=> ##1 byteTimerOutput == initVal)
      else $error("output not at initial value after enable");
   chk_timeout_toggle: assert property (
      byteTimeoutIrq && !bCtrl[BC_DEMOD] |-> byteTimerOutput != $past(byteTimerOutput))
      else $error("timeout without output toggle");
   chk_tmo_gate: assert property (
      byteTimeoutIrq |-> bCtrl[BC_TMO_IE] || $past(bCtrl[BC_TMO_IE], 2))
      else $error("byte timeout irq while disabled");
   chk_edge_gate: assert property (
      byteEdgeIrq |-> bCtrl[BC_EDGE_IE] || $past(bCtrl[BC_EDGE_IE], 2))
      else $error("edge irq while disabled");
   chk_edge_pulse: assert property (
      byteEdgeIrq |=> !byteEdgeIrq)
      else $error("edge irq longer than one cycle");
   chk_wcap_gate: assert property (
      wordCaptureIrq |-> wCtrl[WC_CAP_IE] || $past(wCtrl[WC_CAP_IE], 2))
      else $error("word capture irq while disabled");
   chk_wtmo_gate: assert property (
      wordTimeoutIrq |-> wCtrl[WC_TMO_IE] || $past(wCtrl[WC_TMO_IE], 2))
      else $error("word timeout irq while disabled");
endmodule : ir_timer_checker
`default_nettype wire

// [dv/ir_pulse_src.sv]
`timescale 1ns/1ps
`default_nettype none
module ir_pulse_src (
   input  wire logic mclk,
   output var logic  pinA,
   output var logic  pinB
);
   // Pins idle high through their pull-ups
   initial begin
      pinA = 1'b1;
      pinB = 1'b1;
   end

   // Hold one pin at a level for n clocks, changed on the falling edge
   task automatic hold(input logic useB, input logic lvl, input int n);
      @(negedge mclk);
      if (useB) begin
         pinB = lvl;
      end else begin
         pinA = lvl;
      end
      repeat (n - 1) @(negedge mclk);
   endtask : hold
endmodule : ir_pulse_src
`default_nettype wire

// [dv/tb_ir_pulse_timer_pair.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ir_pulse_timer_pair;
   import ir_timer_pkg::*;
   logic       mclk, rstn, inputPinA, inputPinB, regWrEn, regRdEn;
   logic [7:0] regAddr, regWrData, regRdData;
   logic       byteTimerOutput, byteTimeoutIrq, byteEdgeIrq, wordCaptureIrq, wordTimeoutIrq;
   int         fails, nChecks, nTmo, nEdge, nCap, nWtmo;

   ir_pulse_timer_pair i_dut (.mclk(mclk), .rstn(rstn), .inputPinA(inputPinA), .inputPinB(inputPinB),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn),
      .regRdData(regRdData), .byteTimerOutput(byteTimerOutput), .byteTimeoutIrq(byteTimeoutIrq),
      .byteEdgeIrq(byteEdgeIrq), .wordCaptureIrq(wordCaptureIrq), .wordTimeoutIrq(wordTimeoutIrq));
   ir_pulse_src i_src (.mclk(mclk), .pinA(inputPinA), .pinB(inputPinB));

   // Clock and interrupt pulse counters
   initial begin
      mclk = 1'b0;
      forever #10 mclk = !mclk;
   end
   always @(posedge mclk) begin
      nTmo  += int'(byteTimeoutIrq === 1'b1);
      nEdge += int'(byteEdgeIrq === 1'b1);
      nCap  += int'(wordCaptureIrq === 1'b1);
      nWtmo += int'(wordTimeoutIrq === 1'b1);
   end

   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      nChecks++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   task automatic clr();
      nTmo = 0;
      nEdge = 0;
      nCap = 0;
      nWtmo = 0;
   endtask : clr

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge mclk);
      regAddr = a;
      regWrData = d;
      regWrEn = 1'b1;
      @(negedge mclk);
      regWrEn = 1'b0;
   endtask : wr

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
      @(negedge mclk);
      regAddr = a;
      regRdEn = 1'b1;
      @(negedge mclk);
      regRdEn = 1'b0;
      chk(what, {8'h00, regRdData}, {8'h00, exp});
   endtask : rd_chk

   task automatic regs();
      chk("reset level", {15'h0000, byteTimerOutput}, 16'h0001);
      rd_chk(ADDR_EXTRA_CTRL, 8'h1f, "extra reset");
      wr(ADDR_EXTRA_CTRL, 8'hff);
      rd_chk(ADDR_EXTRA_CTRL, 8'hff, "extra rw");
      wr(ADDR_HIGH_CAPTURE, 8'h5a);
      rd_chk(ADDR_HIGH_CAPTURE, 8'h00, "capture ro");
      rd_chk(8'h0c, RD_UNMAPPED, "unmapped");
   endtask : regs

   // Modulo-N run against a cycle model, low reload changed mid-run
   task automatic modulo_n();
      logic [7:0] cnt;
      logic       o;
      logic       first;
      logic [1:0] ip;
      wr(ADDR_LOW_RELOAD, 8'h03);
      wr(ADDR_HIGH_RELOAD, 8'h02);
      wr(ADDR_SHARED_CTRL, 8'h00);
      wr(ADDR_BYTE_CTRL, 8'h82);
      regAddr = ADDR_LOW_RELOAD;
      regWrData = 8'h04;
      cnt = 8'h03;
      o = 1'b0;
      first = 1'b1;
      ip = 2'b00;
      // Load happens the cycle after the enable write
      @(negedge mclk);
      for (int k = 0; k < 20; k++) begin
         chk("mod output", {15'h0000, byteTimerOutput}, {15'h0000, o});
         chk("mod irq", {15'h0000, byteTimeoutIrq}, {15'h0000, ip[0]});
         ip = {ip[0], 1'b0};
         if (cnt == 8'h01) begin
            o = !o;
            cnt = o ? 8'h02 : 8'h04;
            ip[0] = !first;
            first = 1'b0;
         end else begin
            cnt = cnt - 8'h01;
         end
         @(negedge mclk);
         regWrEn = (k == 0);
      end
      wr(ADDR_BYTE_CTRL, 8'h20);
   endtask : modulo_n

   task automatic single_pass(input logic initV, input logic [7:0] rl);
      int n;
      wr(ADDR_SHARED_CTRL, {6'h00, initV, 1'b0});
      wr(initV ? ADDR_HIGH_RELOAD : ADDR_LOW_RELOAD, rl);
      repeat (2) @(negedge mclk);
      chk("idle level", {15'h0000, byteTimerOutput}, {15'h0000, !initV});
      clr();
      wr(ADDR_BYTE_CTRL, 8'hc2);
      @(negedge mclk);
      n = 0;
      while (byteTimerOutput === initV && n < 300) begin
         n++;
         @(negedge mclk);
      end
      chk("phase ticks", 16'(n), (rl == 8'h00) ? 16'd256 : {8'h00, rl});
      chk("timeout irq", {15'h0000, byteTimeoutIrq}, 16'h0001);
      repeat (4) @(negedge mclk);
      chk("stopped level", {15'h0000, byteTimerOutput}, {15'h0000, !initV});
      chk("irq count", 16'(nTmo), 16'd1);
      rd_chk(ADDR_BYTE_CTRL, 8'he2, "status set");
      wr(ADDR_BYTE_CTRL, 8'h20);
      rd_chk(ADDR_BYTE_CTRL, 8'h00, "status cleared");
   endtask : single_pass

   task automatic demod();
      clr();
      wr(ADDR_SHARED_CTRL, 8'h30);
      wr(ADDR_BYTE_CTRL, 8'h96);
      i_src.hold(1'b0, 1'b0, 20);
      i_src.hold(1'b0, 1'b1, 30);
      i_src.hold(1'b0, 1'b0, 20);
      rd_chk(ADDR_LOW_CAPTURE, 8'hec, "pos capture");
      rd_chk(ADDR_HIGH_CAPTURE, 8'he2, "neg capture");
      rd_chk(ADDR_SHARED_CTRL, 8'h33, "edge status");
      chk("edge irqs", 16'(nEdge), 16'd3);
      repeat (300) @(negedge mclk);
      chk("demod timeouts", 16'(nTmo), 16'd1);
      // Pin b selected, wide filter, positive edges only
      wr(ADDR_SHARED_CTRL, 8'h9f);
      repeat (12) @(negedge mclk);
      clr();
      i_src.hold(1'b1, 1'b0, 12);
      i_src.hold(1'b1, 1'b1, 4);
      i_src.hold(1'b1, 1'b0, 12);
      i_src.hold(1'b1, 1'b1, 12);
      chk("filtered edges", 16'(nEdge), 16'd1);
      rd_chk(ADDR_SHARED_CTRL, 8'h9e, "pos status");
      wr(ADDR_BYTE_CTRL, 8'h20);
   endtask : demod

   task automatic word_once();
      wr(ADDR_SHARED_CTRL, 8'h30);
      wr(ADDR_BYTE_CTRL, 8'h90);
      wr(ADDR_WORD_RLD_HI, 8'h00);
      wr(ADDR_WORD_RLD_LO, 8'h40);
      wr(ADDR_WORD_CTRL, 8'hc6);
      clr();
      i_src.hold(1'b0, 1'b1, 10);
      i_src.hold(1'b0, 1'b0, 10);
      chk("once capture", 16'(nCap), 16'd1);
      repeat (80) @(negedge mclk);
      chk("word wrap", 16'(nWtmo), 16'd1);
      repeat (200) @(negedge mclk);
      chk("timeout capture", 16'(nCap), 16'd2);
      wr(ADDR_WORD_CTRL, 8'h86);
      wr(ADDR_WORD_CTRL, 8'hc6);
      clr();
      i_src.hold(1'b0, 1'b1, 10);
      i_src.hold(1'b0, 1'b0, 10);
      chk("rearm capture", 16'(nCap), 16'd1);
   endtask : word_once

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", nChecks, fails);
      if (fails == 0 && nChecks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Main sequence
   initial begin
      rstn = 1'b0;
      regAddr = 8'h00;
      regWrData = 8'h00;
      regWrEn = 1'b0;
      regRdEn = 1'b0;
      repeat (20) @(posedge mclk);
      @(negedge mclk);
      rstn = 1'b1;
      regs();
      modulo_n();
      single_pass(1'b0, 8'h03);
      single_pass(1'b1, 8'h02);
      single_pass(1'b0, 8'h00);
      demod();
      word_once();
      report_and_stop();
   end

   // Watchdog, far beyond the roughly 1200 cycles the run needs
   initial begin
      repeat (20000) @(posedge mclk);
      fails++;
      report_and_stop();
   end
endmodule : tb_ir_pulse_timer_pair

bind ir_pulse_timer_pair ir_timer_checker #(.TICK_DIV(TICK_DIV)) i_chk (.mclk(mclk), .rstn(rstn),
   .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .byteTimerOutput(byteTimerOutput),
   .byteTimeoutIrq(byteTimeoutIrq), .byteEdgeIrq(byteEdgeIrq), .wordCaptureIrq(wordCaptureIrq),
   .wordTimeoutIrq(wordTimeoutIrq));
`default_nettype wire
